// ===== design/fetch_regs.svh
// constants of the pressure fetch target
`ifndef FETCH_REGS_SVH
`define FETCH_REGS_SVH

`define TARGET_ADDR_DEF 7'h28
`define STAT_GOOD 2'h0
`define STAT_CMD 2'h1
`define STAT_STALE 2'h2
`define STAT_DIAG 2'h3
`define PRESS_W 14
`define TEMP_W 11
`define FAULT_W 4
`define FIFO_DEPTH_DEF 8
`define BITS_PER_BYTE 4'h8
`define LAST_BYTE_IDX 3'h4
`define FILL_BYTE 8'h00
`define TEMP_PAD 5'h00

`endif

// ===== design/fetch_pkg.sv
// types of the pressure fetch target
`include "fetch_regs.svh"

package fetch_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SEND, ST_MACK, ST_IGNORE} link_state_e;
    typedef logic [1:0] status_t;
    typedef logic [`PRESS_W-1:0] press_t;
    typedef logic [`TEMP_W-1:0] temp_t;
    typedef logic [`FAULT_W-1:0] fault_t;
    typedef struct packed {
        logic fault;
        temp_t temp;
        press_t press;
    } meas_s;
endpackage

// ===== design/meas_fifo_if.sv
// handshake carrier between the measurement source and the fetch logic
`timescale 1ns/1ps
`default_nettype none

interface meas_fifo_if #(parameter int W = 26);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    modport fill(output push_valid, output push_data, input push_ready);
    modport store(input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready);
    modport drain(input pop_valid, input pop_data, output pop_ready);
endinterface

`default_nettype wire

// ===== design/meas_fifo.sv
// shift-register fifo holding finished measurements
`timescale 1ns/1ps
`default_nettype none

module meas_fifo #(
    parameter int W = 26,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    meas_fifo_if.store q
);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2) begin : g_bad_depth
        $error("meas_fifo depth must be at least 2");
    end

    logic [W-1:0] entry_r [DEPTH];
    logic [CW-1:0] count_r;
    logic push_ok;
    logic pop_ok;
    logic [CW-1:0] wr_idx;

    assign q.push_ready = (count_r != CW'(DEPTH));
    assign q.pop_valid = (count_r != '0);
    assign q.pop_data = entry_r[0];
    assign push_ok = q.push_valid & q.push_ready;
    assign pop_ok = q.pop_valid & q.pop_ready;
    assign wr_idx = pop_ok ? count_r - CW'(1) : count_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= '0;
        end else if (push_ok && !pop_ok) begin
            count_r <= count_r + CW'(1);
        end else if (pop_ok && !push_ok) begin
            count_r <= count_r - CW'(1);
        end
    end

    // entries move down one place on a pop; the new word lands behind the last
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (push_ok && wr_idx == CW'(i)) begin
                entry_r[i] <= q.push_data;
            end else if (pop_ok && i < DEPTH - 1) begin
                entry_r[i] <= entry_r[i + 1];
            end
        end
    end
endmodule

`default_nettype wire

// ===== design/pressure_fetch_target.sv
// i2c target that serves pressure and temperature packets
//
// Functional notes
// - answer only the configured 7-bit address, default 28 hex; ignore others
// - read begins with address and read bit one; acknowledge a matching address
// - keep sending bytes while the controller acknowledges; nack and stop end it
// - byte one: status in top two bits, pressure 13..8; byte two pressure 7..0
// - after an acknowledged second byte, send temperature bits 10..3
// - fourth byte holds temperature 2..0 on top; controller masks the low five
// - start then stop without clocks poisons the next transaction; extra start heals
// - repeated start during a transfer fails that transaction until a fresh start
// - status 00 fresh data, 01 command mode, 11 diagnostic
// - status 10 when the data was already fetched since the last measurement
// - fetch before the first measurement after reset returns stale
// - status 11 for signature, bridge open, bridge short or source loss faults
// - faults seen in a measurement show up in the following fetch
// - diagnostic holds until the fault is gone and a power-on reset occurs
`timescale 1ns/1ps
`default_nettype none

`include "fetch_regs.svh"

module pressure_fetch_target #(
    parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR_DEF,
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    // i2c pins, sda is open drain
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // measurement source
    input wire logic MEAS_VALID_I,
    output logic MEAS_READY_O,
    input wire fetch_pkg::press_t MEAS_PRESSURE_I,
    input wire fetch_pkg::temp_t MEAS_TEMP_I,
    input wire fetch_pkg::fault_t FAULT_I,
    input wire logic CMD_MODE_I,
    // status seen by the last fetch
    output fetch_pkg::status_t STATUS_O
);
    import fetch_pkg::*;

    localparam int MW = $bits(meas_s);

    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("FIFO_DEPTH must be at least 2");
    end

    // the all-zero and all-one address groups are reserved on the bus
    if (TARGET_ADDR[6:3] == 4'h0 || TARGET_ADDR[6:3] == 4'hf) begin : g_bad_addr
        $error("TARGET_ADDR lies in a reserved address group");
    end

    // pin synchronisers
    logic scl_meta_r;
    logic scl_sync_r;
    logic scl_d_r;
    logic sda_meta_r;
    logic sda_sync_r;
    logic sda_d_r;

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            scl_meta_r <= 1'b1;
            scl_sync_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_meta_r <= 1'b1;
            sda_sync_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_meta_r <= SCL_I;
            scl_sync_r <= scl_meta_r;
            scl_d_r <= scl_sync_r;
            sda_meta_r <= SDA_I;
            sda_sync_r <= sda_meta_r;
            sda_d_r <= sda_sync_r;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // edges come from the synchronised copies, so every pin event is seen two clocks late and acted on at the third
    assign scl_rise = scl_sync_r & ~scl_d_r;
    assign scl_fall = ~scl_sync_r & scl_d_r;
    assign start_det = scl_sync_r & scl_d_r & sda_d_r & ~sda_sync_r;
    assign stop_det = scl_sync_r & scl_d_r & ~sda_d_r & sda_sync_r;

    // measurement fifo
    meas_fifo_if #(.W(MW)) mq ();
    meas_s push_word;

    assign push_word = '{
        fault: |FAULT_I,
        temp: MEAS_TEMP_I,
        press: MEAS_PRESSURE_I
    };
    assign mq.push_valid = MEAS_VALID_I;
    assign mq.push_data = push_word;
    assign MEAS_READY_O = mq.push_ready;

    meas_fifo #(.W(MW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .q(mq.store)
    );

    link_state_e state_r;
    logic fetch_ack;

    // new data is taken only between transactions so a packet never tears
    assign mq.pop_ready = (state_r == ST_IDLE);

    // current measurement, freshness and diagnostic
    meas_s cur_r;
    logic stale_r;
    logic diag_r;
    logic pop_ok;
    meas_s pop_word;

    assign pop_ok = mq.pop_valid & mq.pop_ready;
    assign pop_word = meas_s'(mq.pop_data);

    // an address ack counts as a fetch even when the controller stops early
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            cur_r <= '0;
            stale_r <= 1'b1;
        end else if (pop_ok) begin
            cur_r <= pop_word;
            stale_r <= 1'b0;
        end else if (fetch_ack) begin
            stale_r <= 1'b1;
        end
    end

    // the latch survives a reset while any fault cause is still present
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            diag_r <= diag_r & (|FAULT_I);
        end else if (pop_ok && pop_word.fault) begin
            diag_r <= 1'b1;
        end
    end

    status_t status_now;

    // status priority: diagnostic, then command mode, then stale
    always_comb begin
        if (diag_r) begin
            status_now = `STAT_DIAG;
        end else if (CMD_MODE_I) begin
            status_now = `STAT_CMD;
        end else if (stale_r) begin
            status_now = `STAT_STALE;
        end else begin
            status_now = `STAT_GOOD;
        end
    end

    // start-stop tracking for the poisoned transaction
    logic scl_seen_r;
    logic poison_r;

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I || start_det) begin
            scl_seen_r <= 1'b0;
        end else if (scl_rise) begin
            scl_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            poison_r <= 1'b0;
        end else if (stop_det && state_r != ST_IDLE && !scl_seen_r) begin
            poison_r <= 1'b1;
        end else if (start_det) begin
            poison_r <= 1'b0;
        end
    end

    // link sequencing
    logic [7:0] rx_sr_r;
    logic [7:0] tx_sr_r;
    logic [3:0] bit_cnt_r;
    logic [2:0] byte_idx_r;
    logic sda_oe_r;
    status_t status_r;
    logic [7:0] next_byte;
    logic addr_hit;
    logic in_transfer;

    assign addr_hit = (rx_sr_r[7:1] == TARGET_ADDR) && rx_sr_r[0];
    assign fetch_ack = (state_r == ST_ADDR) && scl_fall && bit_cnt_r == `BITS_PER_BYTE && addr_hit;
    assign in_transfer = (state_r != ST_IDLE) && (state_r != ST_IGNORE);

    always_comb begin
        unique case (byte_idx_r)
            3'h0: next_byte = {status_r, cur_r.press[13:8]};
            3'h1: next_byte = cur_r.press[7:0];
            3'h2: next_byte = cur_r.temp[10:3];
            3'h3: next_byte = {cur_r.temp[2:0], `TEMP_PAD};
            default: next_byte = `FILL_BYTE;
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            status_r <= `STAT_STALE;
        end else if (fetch_ack) begin
            status_r <= status_now;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            state_r <= ST_IDLE;
            rx_sr_r <= '0;
            tx_sr_r <= '0;
            bit_cnt_r <= '0;
            byte_idx_r <= '0;
            sda_oe_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end else if (start_det) begin
            sda_oe_r <= 1'b0;
            bit_cnt_r <= '0;
            if (poison_r || in_transfer) begin
                state_r <= ST_IGNORE;
            end else begin
                state_r <= ST_ADDR;
            end
        end else begin
            unique case (state_r)
                ST_IDLE, ST_IGNORE: begin
                    sda_oe_r <= 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        rx_sr_r <= {rx_sr_r[6:0], sda_sync_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == `BITS_PER_BYTE) begin
                        if (addr_hit) begin
                            state_r <= ST_ADDR_ACK;
                            sda_oe_r <= 1'b1;
                            byte_idx_r <= '0;
                        end else begin
                            state_r <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_MACK: begin
                    if (state_r == ST_MACK && scl_rise && sda_sync_r) begin
                        state_r <= ST_IGNORE;
                    end else if (scl_fall) begin
                        state_r <= ST_SEND;
                        tx_sr_r <= next_byte;
                        sda_oe_r <= ~next_byte[7];
                        bit_cnt_r <= '0;
                        if (byte_idx_r != `LAST_BYTE_IDX) begin
                            byte_idx_r <= byte_idx_r + 3'h1;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_r == `BITS_PER_BYTE) begin
                            state_r <= ST_MACK;
                            sda_oe_r <= 1'b0;
                        end else begin
                            tx_sr_r <= {tx_sr_r[6:0], 1'b0};
                            sda_oe_r <= ~tx_sr_r[6];
                        end
                    end
                end
                // codes outside the enum fall back to idle with the pin released
                default: begin
                    state_r <= ST_IDLE;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // open drain: the pin is only ever pulled low
    assign SDA_O = 1'b0;
    assign SDA_OE_O = sda_oe_r;
    assign STATUS_O = status_r;
endmodule

`default_nettype wire

// ===== bench/fetch_properties.sv
// pin-level assertions for the pressure fetch target
`timescale 1ns/1ps
`default_nettype none
module fetch_chk (
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic SCL_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    input wire logic MEAS_READY_O,
    input wire logic CMD_MODE_I,
    input wire fetch_pkg::status_t STATUS_O
);
    import fetch_pkg::*;
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RESET_I);
    AST_SDA_LOW: assert property (SDA_O == 1'b0)
        else $error("sda drive not low");
    AST_RST_STAT: assert property (disable iff (1'b0) RESET_I |=> STATUS_O == 2'h2 && !SDA_OE_O)
        else $error("bad status or drive after reset");
    AST_RST_RDY: assert property (disable iff (1'b0) RESET_I |=> MEAS_READY_O)
        else $error("fifo not ready after reset");
    AST_OE_EDGE: assert property ($changed(SDA_OE_O) |-> !$past(SCL_I, 3))
        else $error("sda moved while scl high");
    AST_OE_SPAN: assert property ($rose(SDA_OE_O) |-> ##[1:90] !SDA_OE_O)
        else $error("sda held low too long");
    AST_STAT_ACK: assert property ($changed(STATUS_O) |-> ##[0:2] SDA_OE_O)
        else $error("status moved without acknowledge");
    AST_DIAG_HOLD: assert property (STATUS_O == 2'h3 |=> STATUS_O == 2'h3)
        else $error("diagnostic status cleared");
    AST_CMD: assert property ($changed(STATUS_O) && STATUS_O == 2'h1 |-> CMD_MODE_I)
        else $error("command status without command mode");
endmodule
bind pressure_fetch_target fetch_chk fetch_chk_inst (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
    .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .MEAS_READY_O(MEAS_READY_O),
    .CMD_MODE_I(CMD_MODE_I), .STATUS_O(STATUS_O));
`default_nettype wire

// ===== bench/i2c_ctrl.sv
// behavioural i2c controller for the fetch target bench
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl (
    input wire logic clk_i,
    input wire logic sda_i,
    output var logic scl_o,
    output var logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // from idle this is a plain start, from scl low a repeated start
    task automatic start();
        sda_low_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        sda_low_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        scl_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    // from an idle bus this gives a start and stop with no clock between
    task automatic stop();
        @(posedge clk_i);
        sda_low_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        sda_low_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic one_bit(input logic d, output logic r);
        @(posedge clk_i);
        sda_low_o <= !d;
        repeat (3) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        r = sda_i;
        scl_o <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            one_bit(d[i], r);
            q[i] = r;
        end
        one_bit(last, ack);
    endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the pressure fetch target
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fetch_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl;
    logic drv;
    logic oe;
    logic sdo;
    logic vld = 1'b0;
    logic rdy;
    logic cmd = 1'b0;
    logic a;
    logic [7:0] b;
    press_t pr = '0;
    press_t rp;
    temp_t te = '0;
    temp_t rt;
    fault_t fa = '0;
    status_t st;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    wire sda = !(oe || drv);
    always #12.5 clk = ~clk;
    pressure_fetch_target pressure_fetch_target_inst (.SYS_CLK_I(clk), .RESET_I(rst), .SCL_I(scl),
        .SDA_I(sda), .SDA_O(sdo), .SDA_OE_O(oe), .MEAS_VALID_I(vld), .MEAS_READY_O(rdy),
        .MEAS_PRESSURE_I(pr), .MEAS_TEMP_I(te), .FAULT_I(fa), .CMD_MODE_I(cmd), .STATUS_O(st));
    i2c_ctrl i2c_ctrl_inst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(drv));
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            final_report();
        end
    end
    // packet as the controller keeps it, acknowledge in bit 0
    function automatic logic [31:0] pkt(input status_t s, input press_t p, input temp_t t, input int n);
        return ({s, p, t, 5'h00} & ~(32'hffffffff >> (8 * n))) | 32'h1;
    endfunction
    task automatic rd(input int n, input logic [7:0] ab, input logic [31:0] e);
        logic [31:0] q;
        logic ok;
        q = 32'h0;
        i2c_ctrl_inst.start();
        i2c_ctrl_inst.xfer(ab, 1'b1, b, a);
        ok = !a;
        for (int i = 0; i < n && ok; i++) begin
            i2c_ctrl_inst.xfer(8'hff, i == n - 1, b, a);
            q[31 - 8 * i -: 8] = b;
        end
        i2c_ctrl_inst.stop();
        check((q & 32'hffffffe0) | {31'h0, ok}, e);
        if (ok) begin
            check({30'h0, st}, {30'h0, e[31:30]});
        end
    endtask
    task automatic push(input press_t p, input temp_t t, input fault_t f);
        @(posedge clk);
        vld <= 1'b1;
        pr <= p;
        te <= t;
        fa <= f;
        #1;
        while (rdy !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        vld <= 1'b0;
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        void'($urandom(32'he09e6996));
        do_reset();
        rd(2, 8'h51, pkt(2'h2, '0, '0, 2));
        for (int i = 0; i < 9; i++) begin
            rp = (i == 0) ? '1 : (i == 1) ? '0 : press_t'($urandom);
            rt = (i == 0) ? '1 : (i == 1) ? '0 : temp_t'($urandom);
            push(rp, rt, '0);
            rd(2 + i % 3, 8'h51, pkt(2'h0, rp, rt, 2 + i % 3));
            rd(4, 8'h51, pkt(2'h2, rp, rt, 4));
        end
        rd(2, 8'h53, 32'h0);
        rd(2, 8'h50, 32'h0);
        cmd <= 1'b1;
        push(rp, rt, '0);
        rd(2, 8'h51, pkt(2'h1, rp, rt, 2));
        cmd <= 1'b0;
        i2c_ctrl_inst.stop();
        rd(2, 8'h51, 32'h0);
        rd(3, 8'h51, pkt(2'h2, rp, rt, 3));
        i2c_ctrl_inst.start();
        i2c_ctrl_inst.xfer(8'h51, 1'b1, b, a);
        check({31'h0, a}, 32'h0);
        // restart while the device is already shifting its first data byte
        rd(2, 8'h51, 32'h0);
        rd(2, 8'h51, pkt(2'h2, rp, rt, 2));
        // a long read keeps the fifo from draining until it refuses
        fork
            rd(4, 8'h51, pkt(2'h2, rp, rt, 4));
            begin
                repeat (30) @(posedge clk);
                for (int i = 0; i < 8; i++)
                    push(press_t'(i), temp_t'(i), '0);
                @(posedge clk);
                #1;
                check({31'h0, rdy}, 32'h0);
            end
        join
        rd(2, 8'h51, pkt(2'h0, 14'h7, 11'h7, 2));
        check({31'h0, rdy}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            push(rp, rt, fault_t'(1 << i));
            rd(2, 8'h51, pkt(2'h3, rp, rt, 2));
            push(rp, rt, '0);
            rd(2, 8'h51, pkt(2'h3, rp, rt, 2));
            fa <= fault_t'(1 << i);
            do_reset();
            rd(2, 8'h51, pkt(2'h3, '0, '0, 2));
            fa <= '0;
            do_reset();
            rd(2, 8'h51, pkt(2'h2, '0, '0, 2));
        end
        final_report();
    end
endmodule
`default_nettype wire
